// *** rtl/hsl_strap_led.sv ***
// hsl_strap_led: strap sampling, indicator polarity and over-current sense
//
// Contract
// - led support enabled by software forces port 1/2 enhanced leds active low
// - boost strap sampled at hub reset negation sets phy drive level
// - boost 00 both active high, 10 port2 low only, 11 both low
// - over-current inputs are active low, pulled up, flag per port
// - fixed-device strap bits sampled together at hub reset negation
// - fixed-device strap sampled only when enabled, else pin stays serial
// - fixed code 00 all removable, 01 port 1 non-removable
// - fixed code 10 ports 1-2, 11 ports 1-3 non-removable
//
// Added by the designer: the placing of the registers and strobed register access.
module hsl_strap_led
    import hsl_pkg::*;
#(
    parameter int NUM_OC = 7
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clk_en,
    // hub reset pin, straps are caught when it rises
    input wire logic hub_reset_n,
    input wire logic boost_strap_en,
    input wire logic fixed_strap_en,
    // shared enhanced led pins of ports 1 and 2
    input wire logic [1:0] enhanced_led_ports_1_2_in,
    output logic [1:0] enhanced_led_ports_1_2_out,
    output logic [1:0] enhanced_led_ports_1_2_oe,
    // fixed-device strap pins (upper bit shares the serial data pin)
    input wire logic fixed_device_strap_hi,
    input wire logic fixed_device_strap_lo,
    output logic serial_pin_free,
    // over-current sense, active low
    input wire logic [NUM_OC-1:0] overcurrent_sense_in_n,
    output logic [NUM_OC-1:0] overcurrent_flag,
    // strap results toward the phy and hub core
    output logic [1:0] phy_boost_level,
    output logic [2:0] fixed_port_mask,
    output logic straps_valid,
    // register port
    input wire logic [hsl_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [hsl_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [hsl_pkg::DATA_W-1:0] reg_rdata,
    output logic irq
);

    import hsl_pkg::*;

    // positions of each pin group inside the synchronised word
    localparam int SYNC_HUB = 0;
    localparam int SYNC_BOOST_LO = 1;
    localparam int SYNC_FIX_LO = 3;
    localparam int SYNC_FIX_HI = 4;
    localparam int SYNC_OC_LO = 5;
    localparam int SYNC_W = NUM_OC + SYNC_OC_LO;

    initial begin
        if (NUM_OC < 1 || NUM_OC > IRQ_STRAP_BIT) begin
            $error("hsl_strap_led: NUM_OC must lie in 1 to 7");
        end
        // the strap view is the latched record laid out as it stands
        if ($bits(hsl_strap_s) != STRAP_W) begin
            $error("hsl_strap_led: strap record and view differ in width");
        end
        if (STRAP_FIXED_VALID != STRAP_W - 1) begin
            $error("hsl_strap_led: strap valid bits out of place");
        end
        // over-current bits sit below the strap-done bit
        if (IRQ_W != IRQ_STRAP_BIT + 1 || DATA_W < STRAP_W) begin
            $error("hsl_strap_led: register layout does not fit the bus");
        end
    end

    // ****************************************************************
    // functions
    // ****************************************************************

    // fixed-device code to mask of non-removable ports 3..1
    function automatic logic [2:0] fixed_decode(input logic [1:0] code);
        logic [2:0] mask;
        mask = PORTS_NONE;
        unique case (code)
            CODE_00: mask = PORTS_NONE;
            CODE_01: mask = PORTS_P1;
            CODE_10: mask = PORTS_P12;
            CODE_11: mask = PORTS_P123;
        endcase
        return mask;
    endfunction

    // strap and software enable to active-low flags, bit 1 is port 2
    function automatic logic [1:0] led_active_low(input logic [1:0] code,
                                                  input logic valid,
                                                  input logic sw_en);
        logic [1:0] low;
        low = 2'h0;
        if (sw_en) begin
            low = 2'h3;
        end else if (valid) begin
            low = code;
        end
        return low;
    endfunction

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [SYNC_W-1:0] pins_async;
    logic [SYNC_W-1:0] pins_sync;
    logic hub_run_s;
    logic [1:0] boost_pin_s;
    logic fixed_hi_s;
    logic fixed_lo_s;
    logic [NUM_OC-1:0] oc_n_s;

    assign pins_async = {overcurrent_sense_in_n, fixed_device_strap_hi,
                         fixed_device_strap_lo, enhanced_led_ports_1_2_in,
                         hub_reset_n};

    hsl_sync #(
        .WIDTH(SYNC_W),
        .RST_VAL({SYNC_W{1'b1}})
    ) u_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .async_in(pins_async),
        .sync_out(pins_sync)
    );

    // split the synchronised group
    assign hub_run_s = pins_sync[SYNC_HUB];
    assign boost_pin_s = pins_sync[SYNC_BOOST_LO +: $bits(boost_pin_s)];
    assign fixed_lo_s = pins_sync[SYNC_FIX_LO];
    assign fixed_hi_s = pins_sync[SYNC_FIX_HI];
    assign oc_n_s = pins_sync[SYNC_W-1:SYNC_OC_LO];

    // ****************************************************************
    // hub reset sequencing
    // ****************************************************************
    // sync flops idle high, so a hub reset already high is caught at once
    hsl_state_e state_reg;
    hsl_state_e state_next;

    // held in reset, sample one cycle after negation, then run
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            HSL_HELD: begin
                if (hub_run_s) begin
                    state_next = HSL_SAMPLE;
                end
            end
            HSL_SAMPLE: begin
                state_next = hub_run_s ? HSL_RUN : HSL_HELD;
            end
            HSL_RUN: begin
                if (!hub_run_s) begin
                    state_next = HSL_HELD;
                end
            end
            default: begin
                state_next = HSL_HELD;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= HSL_HELD;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // strap latch
    // ****************************************************************
    hsl_strap_s strap_reg;
    hsl_strap_s strap_next;
    wire sample_now = (state_reg == HSL_SAMPLE);

    // capture at negation, hold until the next hub reset
    always_comb begin
        strap_next = strap_reg;
        if (sample_now) begin
            strap_next.boost_valid = boost_strap_en;
            strap_next.boost_code = boost_strap_en ? boost_pin_s
                                                   : CODE_00;
            strap_next.fixed_valid = fixed_strap_en;
            strap_next.fixed_code = fixed_strap_en
                ? {fixed_hi_s, fixed_lo_s} : CODE_00;
            strap_next.fixed_ports = fixed_strap_en
                ? fixed_decode({fixed_hi_s, fixed_lo_s}) : PORTS_NONE;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            strap_reg <= STRAP_RST;
        end else if (clk_en) begin
            strap_reg <= strap_next;
        end
    end

    assign phy_boost_level = strap_reg.boost_code;
    assign fixed_port_mask = strap_reg.fixed_ports;
    assign straps_valid = (state_reg == HSL_RUN);
    // serial data function is given up from hub reset until run while the fixed strap is enabled
    assign serial_pin_free = !(fixed_strap_en && state_reg != HSL_RUN);

    // ****************************************************************
    // control register
    // ****************************************************************
    logic [CTRL_W-1:0] ctrl_reg;
    // write decodes, one per writable register
    wire wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
    wire wr_istat = reg_wr && (reg_addr == ADDR_ISTAT);
    wire wr_imask = reg_wr && (reg_addr == ADDR_IMASK);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= CTRL_RST;
        end else if (clk_en && wr_ctrl) begin
            ctrl_reg <= reg_wdata[CTRL_W-1:0];
        end
    end

    // ****************************************************************
    // enhanced led pins
    // ****************************************************************
    logic [1:0] led_low;
    logic [1:0] led_on;
    logic [1:0] led_level_reg;
    logic [1:0] led_oe_reg;

    assign led_low = led_active_low(strap_reg.boost_code,
                                    strap_reg.boost_valid,
                                    ctrl_reg[CTRL_LED_SUPPORT]);
    // on bits come straight from software, polarity is applied after
    assign led_on = ctrl_reg[CTRL_LED_ON_HI:CTRL_LED_ON_LO];

    // pins float during hub reset so the straps can be read
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            led_level_reg <= 2'h0;
            led_oe_reg <= 2'h0;
        end else if (clk_en) begin
            led_level_reg <= led_on ^ led_low;
            led_oe_reg <= {2{state_next == HSL_RUN}};
        end
    end

    assign enhanced_led_ports_1_2_out = led_level_reg;
    assign enhanced_led_ports_1_2_oe = led_oe_reg;

    // ****************************************************************
    // over-current sense
    // ****************************************************************
    logic [NUM_OC-1:0] oc_reg;
    logic [NUM_OC-1:0] oc_rise;

    // low on the pin means over-current on that port
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            oc_reg <= '0;
        end else if (clk_en) begin
            oc_reg <= ~oc_n_s;
        end
    end

    assign oc_rise = ~oc_n_s & ~oc_reg;
    assign overcurrent_flag = oc_reg;

    // ****************************************************************
    // interrupt status and mask
    // ****************************************************************
    logic [IRQ_W-1:0] istat_reg;
    logic [IRQ_W-1:0] istat_next;
    logic [IRQ_W-1:0] imask_reg;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    logic [IRQ_STRAP_BIT-1:0] oc_evt;

    // over-current events widened up to the strap-done bit
    assign oc_evt = IRQ_STRAP_BIT'(oc_rise);
    assign irq_set = {sample_now, oc_evt};
    assign irq_clr = wr_istat ? reg_wdata[IRQ_W-1:0] : IRQ_RST;
    // a new event beats a clear in the same cycle
    assign istat_next = (istat_reg & ~irq_clr) | irq_set;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            istat_reg <= IRQ_RST;
            imask_reg <= IRQ_RST;
        end else if (clk_en) begin
            istat_reg <= istat_next;
            if (wr_imask) begin
                imask_reg <= reg_wdata[IRQ_W-1:0];
            end
        end
    end

    // level output, high while any unmasked event stands
    assign irq = |(istat_reg & imask_reg);

    // ****************************************************************
    // register read path
    // ****************************************************************
    logic [DATA_W-1:0] rd_mux;
    logic [DATA_W-1:0] rdata_reg;
    logic [STRAP_W-1:0] strap_view;

    assign strap_view = {strap_reg.fixed_valid, strap_reg.boost_valid,
                         strap_reg.fixed_ports, strap_reg.fixed_code,
                         strap_reg.boost_code};

    // unmapped addresses read as zero
    always_comb begin
        rd_mux = '0;
        unique case (reg_addr)
            ADDR_CTRL: rd_mux[CTRL_W-1:0] = ctrl_reg;
            ADDR_STRAP: rd_mux[STRAP_W-1:0] = strap_view;
            ADDR_OC: rd_mux[NUM_OC-1:0] = oc_reg;
            ADDR_ISTAT: rd_mux[IRQ_W-1:0] = istat_reg;
            ADDR_IMASK: rd_mux[IRQ_W-1:0] = imask_reg;
            default: rd_mux = '0;
        endcase
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= '0;
        end else if (clk_en) begin
            rdata_reg <= reg_rd ? rd_mux : '0;
        end
    end

    assign reg_rdata = rdata_reg;

endmodule // hsl_strap_led

// *** rtl/hsl_pkg.sv ***
// hsl_pkg: shared constants and types for the hub strap and indicator block
package hsl_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STRAP = 8'h04;
    localparam logic [7:0] ADDR_OC = 8'h08;
    localparam logic [7:0] ADDR_ISTAT = 8'h0C;
    localparam logic [7:0] ADDR_IMASK = 8'h10;

    // ****************************************************************
    // control register fields
    // ****************************************************************
    localparam int CTRL_LED_SUPPORT = 0;
    localparam int CTRL_LED_ON_LO = 1;
    localparam int CTRL_LED_ON_HI = 2;
    localparam int CTRL_W = 3;
    localparam logic [2:0] CTRL_RST = 3'h0;

    // ****************************************************************
    // strap register fields
    // ****************************************************************
    localparam int STRAP_BOOST_LO = 0;
    localparam int STRAP_FIXED_LO = 2;
    localparam int STRAP_PORTS_LO = 4;
    localparam int STRAP_BOOST_VALID = 7;
    localparam int STRAP_FIXED_VALID = 8;
    localparam int STRAP_W = 9;

    // ****************************************************************
    // interrupt status layout: over-current bits, then strap-done bit
    // ****************************************************************
    localparam int IRQ_STRAP_BIT = 7;
    localparam int IRQ_W = 8;
    localparam logic [7:0] IRQ_RST = 8'h00;

    // ****************************************************************
    // strap codes
    // ****************************************************************
    localparam logic [1:0] CODE_00 = 2'h0;
    localparam logic [1:0] CODE_01 = 2'h1;
    localparam logic [1:0] CODE_10 = 2'h2;
    localparam logic [1:0] CODE_11 = 2'h3;
    localparam logic [2:0] PORTS_NONE = 3'h0;
    localparam logic [2:0] PORTS_P1 = 3'h1;
    localparam logic [2:0] PORTS_P12 = 3'h3;
    localparam logic [2:0] PORTS_P123 = 3'h7;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [1:0] {
        HSL_HELD = 2'b00,
        HSL_SAMPLE = 2'b01,
        HSL_RUN = 2'b11
    } hsl_state_e;

    typedef struct packed {
        logic fixed_valid;
        logic boost_valid;
        logic [2:0] fixed_ports;
        logic [1:0] fixed_code;
        logic [1:0] boost_code;
    } hsl_strap_s;

    localparam hsl_strap_s STRAP_RST = '0;

endpackage : hsl_pkg

// *** rtl/hsl_sync.sv ***
// hsl_sync: two-flop synchroniser for a group of pin inputs
module hsl_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    initial begin
        if (WIDTH < 1) begin
            $error("hsl_sync: WIDTH must be at least one");
        end
    end

    // ****************************************************************
    // first flop feeds only the second
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= RST_VAL;
            sync_reg <= RST_VAL;
        end else if (clk_en) begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;

endmodule // hsl_sync

// *** verif/hsl_strap_led_chk.sv ***
// hsl_strap_led_chk: concurrent checks on the strap and indicator block
module hsl_strap_led_chk #(
    parameter int NUM_OC = 7
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic boost_strap_en,
    input wire logic fixed_strap_en,
    input wire logic [1:0] enhanced_led_ports_1_2_in,
    input wire logic [1:0] enhanced_led_ports_1_2_oe,
    input wire logic serial_pin_free,
    input wire logic [NUM_OC-1:0] overcurrent_sense_in_n,
    input wire logic [NUM_OC-1:0] overcurrent_flag,
    input wire logic [1:0] phy_boost_level,
    input wire logic [2:0] fixed_port_mask,
    input wire logic straps_valid,
    input wire logic reg_rd,
    input wire logic [hsl_pkg::DATA_W-1:0] reg_rdata
);
    import hsl_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    // first run cycle, straps just latched
    sequence s_latch;
        $rose(straps_valid);
    endsequence
    // boost pins held steady through the synchroniser
    sequence s_boost_steady;
        $past(nrst, 4) && $past(boost_strap_en)
        && $past(enhanced_led_ports_1_2_in, 2)
        == $past(enhanced_led_ports_1_2_in, 4);
    endsequence

    property p_boost_take;
        s_latch and s_boost_steady |->
        phy_boost_level == $past(enhanced_led_ports_1_2_in, 3);
    endproperty
    a_boost_take: assert property (p_boost_take)
        else $error("boost level differs from sampled pins");
    property p_boost_off;
        s_latch and !$past(boost_strap_en) |-> phy_boost_level == 2'h0;
    endproperty
    a_boost_off: assert property (p_boost_off)
        else $error("disabled boost strap latched a level");
    property p_fixed_off;
        s_latch and !$past(fixed_strap_en) |-> fixed_port_mask == 3'h0;
    endproperty
    a_fixed_off: assert property (p_fixed_off)
        else $error("disabled fixed strap latched ports");
    property p_mask_shape;
        straps_valid |-> fixed_port_mask inside {3'h0, 3'h1, 3'h3, 3'h7};
    endproperty
    a_mask_shape: assert property (p_mask_shape)
        else $error("fixed port mask not a legal decode");
    property p_hold;
        straps_valid && $past(straps_valid) |->
        $stable(phy_boost_level) && $stable(fixed_port_mask);
    endproperty
    a_hold: assert property (p_hold)
        else $error("latched strap changed while running");
    property p_oe_run;
        s_latch |-> enhanced_led_ports_1_2_oe == 2'h3;
    endproperty
    a_oe_run: assert property (p_oe_run)
        else $error("led pins not driven on entering run");
    property p_serial;
        serial_pin_free == !(fixed_strap_en && !straps_valid);
    endproperty
    a_serial: assert property (p_serial)
        else $error("serial pin release wrong");
    property p_oc;
        $stable(overcurrent_sense_in_n) [*4] |->
        overcurrent_flag == ~overcurrent_sense_in_n;
    endproperty
    a_oc: assert property (p_oc)
        else $error("over-current flag does not follow pins");
    property p_rdata_idle;
        !$past(reg_rd) |-> reg_rdata == '0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data present without a read");
endmodule // hsl_strap_led_chk

bind hsl_strap_led hsl_strap_led_chk #(.NUM_OC(NUM_OC)) hsl_strap_led_chk_i (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .boost_strap_en(boost_strap_en),
    .fixed_strap_en(fixed_strap_en),
    .enhanced_led_ports_1_2_in(enhanced_led_ports_1_2_in),
    .enhanced_led_ports_1_2_oe(enhanced_led_ports_1_2_oe),
    .serial_pin_free(serial_pin_free),
    .overcurrent_sense_in_n(overcurrent_sense_in_n),
    .overcurrent_flag(overcurrent_flag),
    .phy_boost_level(phy_boost_level),
    .fixed_port_mask(fixed_port_mask),
    .straps_valid(straps_valid),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata)
);

// *** verif/hsl_far_model.sv ***
// hsl_far_model: strap pulls, indicator leds and current monitors at pins
module hsl_far_model (
    input wire logic [1:0] led_out,
    input wire logic [1:0] led_oe,
    input wire logic [1:0] boost_pull,
    input wire logic fixed_pull_hi,
    input wire logic fixed_pull_lo,
    input wire logic [6:0] monitor_fault,
    output logic [1:0] led_pin,
    output logic fixed_pin_hi,
    output logic fixed_pin_lo,
    output logic [6:0] oc_pin_n
);
    // led wire: design level when driven, strap resistor otherwise
    assign led_pin = (led_oe & led_out) | (~led_oe & boost_pull);
    // strap resistors hold the fixed-device pins
    assign fixed_pin_hi = fixed_pull_hi;
    assign fixed_pin_lo = fixed_pull_lo;
    // monitor pulls low on fault, internal pull-up otherwise
    assign oc_pin_n = ~monitor_fault;
endmodule // hsl_far_model

// *** verif/testbench.sv ***
// testbench: register and strap sequences for the strap and indicator block
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import hsl_pkg::*;
    logic sys_clk = 0, nrst = 0, hub_reset_n = 0;
    logic boost_strap_en = 1, fixed_strap_en = 1;
    logic [1:0] boost_pull = 0, code;
    logic fixed_pull_hi = 0, fixed_pull_lo = 0;
    logic [6:0] monitor_fault = 0, oc_pin_n, oc_flag;
    logic [7:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata;
    logic reg_wr = 0, reg_rd = 0, fix_hi, fix_lo, serial_pin_free;
    logic [1:0] led_out, led_oe, led_pin, phy_boost_level;
    logic [2:0] fixed_port_mask, mask;
    logic straps_valid, irq;
    logic [2:0] mask_tab [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
    int fails = 0, checks_done = 0;

    // clock source, 50 ns period
    always #25 sys_clk = ~sys_clk;

    hsl_strap_led #(.NUM_OC(7)) hsl_strap_led_i (
        .sys_clk(sys_clk), .nrst(nrst), .clk_en(1'b1),
        .hub_reset_n(hub_reset_n), .boost_strap_en(boost_strap_en),
        .fixed_strap_en(fixed_strap_en),
        .enhanced_led_ports_1_2_in(led_pin),
        .enhanced_led_ports_1_2_out(led_out),
        .enhanced_led_ports_1_2_oe(led_oe),
        .fixed_device_strap_hi(fix_hi), .fixed_device_strap_lo(fix_lo),
        .serial_pin_free(serial_pin_free),
        .overcurrent_sense_in_n(oc_pin_n), .overcurrent_flag(oc_flag),
        .phy_boost_level(phy_boost_level), .fixed_port_mask(fixed_port_mask),
        .straps_valid(straps_valid), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq)
    );
    hsl_far_model hsl_far_model_i (
        .led_out(led_out), .led_oe(led_oe), .boost_pull(boost_pull),
        .fixed_pull_hi(fixed_pull_hi), .fixed_pull_lo(fixed_pull_lo),
        .monitor_fault(monitor_fault), .led_pin(led_pin),
        .fixed_pin_hi(fix_hi), .fixed_pin_lo(fix_lo), .oc_pin_n(oc_pin_n)
    );

    task automatic end_sim;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // one-cycle read strobe, data checked in the following cycle
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    // control write, then led pin level one edge later
    task automatic wr_led(input logic [31:0] d, input logic [1:0] exp);
        wr(ADDR_CTRL, d);
        @(posedge sys_clk);
        #1 chk(32'(led_pin), 32'(exp));
    endtask
    // hub reset pulse with strap pulls and enables set
    task automatic hub_cycle(input logic [1:0] b, input logic [1:0] f,
                             input logic en_b, input logic en_f);
        @(posedge sys_clk);
        hub_reset_n <= 1'b0;
        boost_pull <= b;
        fixed_pull_hi <= f[1];
        fixed_pull_lo <= f[0];
        boost_strap_en <= en_b;
        fixed_strap_en <= en_f;
        repeat (6) @(posedge sys_clk);
        #1 chk(32'(serial_pin_free), 32'(!en_f));
        @(posedge sys_clk);
        hub_reset_n <= 1'b1;
        for (int n = 0; n < 12 && straps_valid !== 1'b1; n++) begin
            @(posedge sys_clk);
        end
        #1;
    endtask

    // watchdog against a hang
    initial begin
        #(50 * 5000);
        fails++;
        end_sim();
    end

    // main sequence
    initial begin
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            code = 2'(i);
            mask = mask_tab[i];
            hub_cycle(code, code, 1'b1, 1'b1);
            chk(32'(phy_boost_level), 32'(code));
            chk(32'(fixed_port_mask), 32'(mask));
            rd(ADDR_STRAP, {23'h0, 2'b11, mask, code, code});
            chk(32'(led_pin), 32'(code));
            wr_led(32'h6, code ^ 2'h3);
            wr_led(32'h1, 2'h3);
            wr_led(32'h7, 2'h0);
            wr_led(32'h0, code);
        end
        // straps kept while pins move afterwards
        @(posedge sys_clk);
        boost_pull <= 2'h0;
        fixed_pull_hi <= 1'b0;
        fixed_pull_lo <= 1'b0;
        repeat (5) @(posedge sys_clk);
        #1 chk(32'(fixed_port_mask), 32'h7);
        chk(32'(phy_boost_level), 32'h3);
        // both straps disabled
        hub_cycle(2'h3, 2'h3, 1'b0, 1'b0);
        chk(32'(phy_boost_level), 32'h0);
        chk(32'(fixed_port_mask), 32'h0);
        chk(32'(serial_pin_free), 32'h1);
        rd(ADDR_STRAP, 32'h0);
        wr_led(32'h6, 2'h3);
        wr(ADDR_STRAP, 32'hFFFFFFFF);
        rd(ADDR_STRAP, 32'h0);
        rd(8'h20, 32'h0);
        // over-current on port 3, interrupt mask and clear
        wr(ADDR_ISTAT, 32'hFF);
        rd(ADDR_ISTAT, 32'h0);
        @(posedge sys_clk);
        monitor_fault <= 7'h04;
        repeat (4) @(posedge sys_clk);
        #1 chk(32'(oc_flag), 32'h04);
        rd(ADDR_OC, 32'h04);
        rd(ADDR_ISTAT, 32'h04);
        chk(32'(irq), 32'h0);
        wr(ADDR_IMASK, 32'h04);
        #1 chk(32'(irq), 32'h1);
        rd(ADDR_IMASK, 32'h04);
        wr(ADDR_ISTAT, 32'h04);
        #1 chk(32'(irq), 32'h0);
        rd(ADDR_ISTAT, 32'h0);
        @(posedge sys_clk);
        monitor_fault <= 7'h00;
        repeat (4) @(posedge sys_clk);
        #1 chk(32'(oc_flag), 32'h0);
        // strap completion raises the interrupt
        wr(ADDR_IMASK, 32'h80);
        #1 chk(32'(irq), 32'h0);
        hub_cycle(2'h1, 2'h2, 1'b1, 1'b1);
        chk(32'(irq), 32'h1);
        chk(32'(fixed_port_mask), 32'h3);
        end_sim();
    end
endmodule // testbench
